// ==== verification/enc_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// encoder or pulse source
// ****************
module enc_source_model (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// stimulus: move 01 forward, 10 backward; idx drives the third track
	input wire logic pulse_mode,
	input wire logic [1:0] move,
	input wire logic idx,
	// tracks toward the counter
	output wire enc_counter_pkg::tracks_t tracks
);
	logic [1:0] ph_r;
	logic pa_r;
	logic pb_r;
	// quadrature phase or pulse train, one phase step or one pulse per request
	always_ff @(posedge clk) begin
		if (srst) begin
			ph_r <= 2'h0;
			pa_r <= 1'b0;
			pb_r <= 1'b0;
		end else if (pulse_mode) begin
			pa_r <= move != 2'h0;
			if (move != 2'h0) pb_r <= move[1];
		end else begin
			ph_r <= ph_r + {1'b0, move == 2'h1} - {1'b0, move == 2'h2};
		end
	end
	// gray order 00,10,11,01 keeps the first track leading when moving forward
	assign tracks = '{a: pulse_mode ? pa_r : ^ph_r, b: pulse_mode ? pb_r : ph_r[1], c: idx};
endmodule
`default_nettype wire

// ==== verification/test_incremental_encoder_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module test_incremental_encoder_counter;
	import enc_counter_pkg::*;
	typedef struct packed {logic [3:0] ad; logic [31:0] ex;} row_t;
	logic clk, srst, irq, pmode, idx;
	logic [1:0] move;
	logic [31:0] rd;
	avm_req_t req;
	avm_rsp_t rsp;
	tracks_t trk, led;
	int bad_count, check_count;
	// reset values, unmapped places read zero
	row_t rows[8] = '{'{4'h0, 32'h4}, '{4'h1, 32'h0}, '{4'h2, 32'h0}, '{4'h3, 32'h0},
		'{4'h4, 32'h0}, '{4'h5, 32'h0}, '{4'h6, 32'h0}, '{4'hF, 32'h0}};
	incremental_encoder_counter u_incremental_encoder_counter (.clk(clk), .srst(srst),
		.avm_req(req), .avm_rsp(rsp), .tracks(trk), .led(led), .irq(irq));
	enc_source_model u_enc_source_model (.clk(clk), .srst(srst), .pulse_mode(pmode),
		.move(move), .idx(idx), .tracks(trk));
	// ****************
	// bus and stimulus tasks
	// ****************
	// hold the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic [3:0] ad, input logic wr, input logic [31:0] wd);
		req.address <= ad;
		req.write <= wr;
		req.read <= !wr;
		req.writedata <= wd;
		// no fixed latency assumed, the watchdog ends a hang
		do @(posedge clk); while (rsp.waitrequest !== 1'b0);
		rd = rsp.readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge clk);
	endtask
	// one step every ten cycles is the top documented rate
	task automatic mv(input logic [1:0] m);
		move <= m;
		@(posedge clk);
		move <= 2'h0;
		repeat (9) @(posedge clk);
	endtask
	task automatic end_sim;
		if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_sim;
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		srst = 1'b1; req = '0; move = 2'h0; idx = 1'b0; pmode = 1'b0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			bus(rows[i].ad, 1'b0, 32'h0);
			`CHK(rd, rows[i].ex)
		end
		repeat (4) mv(2'h1);
		bus(4'h2, 1'b0, 32'h0);
		`CHK(rd, 32'h4)
		repeat (6) mv(2'h2);
		bus(4'h2, 1'b0, 32'h0);
		`CHK(rd, 32'hFFFE)
		bus(4'h5, 1'b0, 32'h0);
		`CHK(rd[2:0], 3'h4)
		`CHK(irq, 1'b0)
		bus(4'h6, 1'b1, 32'h4);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		bus(4'h5, 1'b1, 32'h4);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		bus(4'h1, 1'b0, 32'h0);
		`CHK(rd[5:0], 6'h1C)
		bus(4'h2, 1'b1, 32'hFFFF);
		repeat (2) mv(2'h1);
		bus(4'h2, 1'b0, 32'h0);
		`CHK(rd, 32'h1)
		bus(4'h1, 1'b0, 32'h0);
		`CHK(rd[2:0], 3'h2)
		bus(4'h0, 1'b1, 32'h0);
		mv(2'h1);
		bus(4'h2, 1'b0, 32'h0);
		`CHK(rd, 32'h1)
		bus(4'h0, 1'b1, 32'h5);
		idx <= 1'b1;
		repeat (3) @(posedge clk);
		idx <= 1'b0;
		bus(4'h3, 1'b1, 32'h1234);
		bus(4'h3, 1'b0, 32'h0);
		`CHK(rd, 32'h1)
		bus(4'h1, 1'b0, 32'h0);
		`CHK(rd[0], 1'b1)
		bus(4'h0, 1'b1, 32'hC);
		pmode <= 1'b1;
		bus(4'h2, 1'b1, 32'h10);
		repeat (3) mv(2'h1);
		repeat (2) mv(2'h2);
		idx <= 1'b1;
		repeat (2) mv(2'h1);
		bus(4'h2, 1'b0, 32'h0);
		`CHK(rd, 32'h11)
		bus(4'h4, 1'b0, 32'h0);
		`CHK(rd, 32'h5)
		bus(4'h1, 1'b0, 32'h0);
		`CHK(rd[5:3], 3'b100)
		`CHK(rd[6], 1'b1)
		`CHK(led, 3'b001)
		// reset in mid-run brings back the defaults
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		bus(4'h2, 1'b0, 32'h0);
		`CHK(rd, 32'h0)
		bus(4'h0, 1'b0, 32'h0);
		`CHK(rd, 32'h4)
		end_sim;
	end
endmodule
`undef CHK
`default_nettype wire

// ==== verilog/enc_counter_map.svh ====
`ifndef ENC_COUNTER_MAP_SVH
`define ENC_COUNTER_MAP_SVH
// register byte addresses
`define OFS_CTRL 4'h0
`define OFS_STAT 4'h1
`define OFS_COUNT 4'h2
`define OFS_LATCH 4'h3
`define OFS_PERIOD 4'h4
`define OFS_IRQ_STAT 4'h5
`define OFS_IRQ_MASK 4'h6
// control byte fields
`define CTRL_ARM 0
`define CTRL_SET 1
`define CTRL_ENABLE 2
`define CTRL_MODE 3
// status byte fields
`define STAT_LATCH_VALID 0
`define STAT_OVERFLOW 1
`define STAT_UNDERFLOW 2
`define STAT_IN_A 3
`define STAT_IN_B 4
`define STAT_IN_C 5
`define STAT_PERIOD_VALID 6
// event bit positions
`define EV_LATCH 0
`define EV_OVERFLOW 1
`define EV_UNDERFLOW 2
`define EV_PERIOD 3
// timing
`define CLK_PERIOD_NS 100
`define PERIOD_RES_NS 200
`define PERIOD_DIV ((`PERIOD_RES_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reset values
`define CTRL_RST 8'h04
`define IRQ_MASK_RST 4'h0
`endif

// ==== verilog/enc_counter_pkg.sv ====
`default_nettype none
package enc_counter_pkg;
	// avalon register bus request
	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} avm_req_t;
	// avalon answer
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} avm_rsp_t;
	// encoder track levels
	typedef struct packed {
		logic a;
		logic b;
		logic c;
	} tracks_t;
	typedef enum logic [1:0] {
		MODE_ENCODER = 2'b01,
		MODE_PULSE = 2'b10
	} count_mode_t;
endpackage
`default_nettype wire

// ==== verilog/incremental_encoder_counter.sv ====
// Behaviour
// - 16-bit position counter fed by quadrature decoder in encoder mode.
// - encoder mode counts every edge of both phase tracks; edges on A and B in the same sample are not counted.
// - counts rates up to one million increments per second without loss.
// - 16-bit latch captures the counter on an index pulse.
// - armed capture stores the count at next index and flags valid; the code captures in encoder mode only.
// - read, set and enable commands; set loads the supplied count.
// - period between rising edges of track A, 200 ns per count.
// - two modes, selected by configuration; encoder mode by default.
// - pulse mode counts each rising edge of track A.
// - pulse mode: B low counts up, B high counts down.
// - pulse mode: C low enables counting, C high freezes.
// - status reports counter overflow and underflow.
// - live levels of A, B and C appear in the status data.
// - process image is always six bytes each way.
// - control or status byte at lowest offset, then two 16-bit words.
// - first word is the counter, second is the read-only latch.
// - one indicator output per track, high while input is high.
`timescale 1ns/1ps
`default_nettype none
`include "enc_counter_map.svh"
module incremental_encoder_counter (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register bus
	input wire enc_counter_pkg::avm_req_t avm_req,
	output enc_counter_pkg::avm_rsp_t avm_rsp,
	// encoder tracks
	input wire enc_counter_pkg::tracks_t tracks,
	// indicators and interrupt
	output enc_counter_pkg::tracks_t led,
	output logic irq
);
	import enc_counter_pkg::*;

	// ****************************************
	// input edges
	// ****************************************
	tracks_t prev_r;
	// inputs are synchronous, one stage of history is enough for edges
	always_ff @(posedge clk) begin
		if (srst) begin
			prev_r <= '0;
		end else begin
			prev_r <= tracks;
		end
	end
	wire a_rise = tracks.a & ~prev_r.a;
	wire a_chg = tracks.a ^ prev_r.a;
	wire b_chg = tracks.b ^ prev_r.b;
	wire c_rise = tracks.c & ~prev_r.c;

	// ****************************************
	// control byte
	// ****************************************
	logic [7:0] ctrl_r;
	logic [3:0] irq_stat_r;
	logic [3:0] irq_mask_r;
	logic arm_r;
	logic latch_valid_r;
	logic ovf_r;
	logic unf_r;
	logic period_valid_r;
	logic [15:0] count_r;
	logic [15:0] latch_r;
	logic [15:0] period_r;
	logic [15:0] period_cnt_r;
	logic [1:0] div_r;
	logic seen_a_r;
	logic waited_r;

	// bus decode
	wire acc = (avm_req.read | avm_req.write) & ~waited_r;
	// writes land at the edge where the master sees waitrequest low
	wire wr = avm_req.write & waited_r;
	wire wr_ctrl = wr & (avm_req.address == `OFS_CTRL);
	wire wr_count = wr & (avm_req.address == `OFS_COUNT);
	wire wr_istat = wr & (avm_req.address == `OFS_IRQ_STAT);
	wire wr_imask = wr & (avm_req.address == `OFS_IRQ_MASK);
	wire rd_stat = avm_req.read & ~waited_r & (avm_req.address == `OFS_STAT);
	wire count_mode_t mode = ctrl_r[`CTRL_MODE] ? MODE_PULSE : MODE_ENCODER;
	wire enabled = ctrl_r[`CTRL_ENABLE];

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_r <= `CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= avm_req.writedata[7:0];
		end
	end

	// ****************************************
	// decoder and counter
	// ****************************************
	// fourfold: every edge on A or B, one step per sample
	// direction: A leads B gives up
	wire enc_step = (mode == MODE_ENCODER) & (a_chg ^ b_chg);
	wire enc_up = a_chg ? (tracks.a ^ tracks.b) : ~(tracks.a ^ tracks.b);
	wire pls_step = (mode == MODE_PULSE) & a_rise & ~tracks.c;
	wire pls_up = ~tracks.b;
	wire step = enabled & (enc_step | pls_step);
	wire up = (mode == MODE_ENCODER) ? enc_up : pls_up;
	// a set in the same cycle overrides the step, so no wrap is reported
	wire ovf_ev = step & ~wr_count & up & (count_r == 16'hFFFF);
	wire unf_ev = step & ~wr_count & ~up & (count_r == 16'h0000);
	// one step per 100 ns clock covers 1 M increments per second
	wire [15:0] count_nxt = up ? count_r + 16'h0001 : count_r - 16'h0001;

	// set command loads the written count word
	always_ff @(posedge clk) begin
		if (srst) begin
			count_r <= 16'h0000;
		end else if (wr_count) begin
			count_r <= avm_req.writedata[15:0];
		end else if (step) begin
			count_r <= count_nxt;
		end
	end

	// ****************************************
	// index latch
	// ****************************************
	// capture armed by a one in the arm bit
	wire arm_set = wr_ctrl & avm_req.writedata[`CTRL_ARM];
	wire capture = arm_r & c_rise & (mode == MODE_ENCODER);
	always_ff @(posedge clk) begin
		if (srst) begin
			arm_r <= 1'b0;
			latch_r <= 16'h0000;
			latch_valid_r <= 1'b0;
		end else begin
			if (capture) begin
				latch_r <= count_r;
			end
			arm_r <= arm_set | (arm_r & ~capture);
			// valid flag: capture wins over new arm clearing it
			latch_valid_r <= capture | (latch_valid_r & ~arm_set);
		end
	end

	// ****************************************
	// period measurement
	// ****************************************
	// counts 200 ns ticks between rising edges of A, any mode
	wire tick = (div_r == 2'(`PERIOD_DIV - 1));
	always_ff @(posedge clk) begin
		if (srst) begin
			div_r <= 2'h0;
			period_cnt_r <= 16'h0000;
			period_r <= 16'h0000;
			seen_a_r <= 1'b0;
			period_valid_r <= 1'b0;
		end else if (a_rise) begin
			// first tick one clock later, so a whole span of ticks fits before the next rise
			div_r <= 2'(`PERIOD_DIV - 1);
			period_cnt_r <= 16'h0000;
			seen_a_r <= 1'b1;
			if (seen_a_r) begin
				period_r <= period_cnt_r;
				period_valid_r <= 1'b1;
			end
		end else begin
			div_r <= tick ? 2'h0 : div_r + 2'h1;
			// saturate rather than wrap, slow signals read as full scale
			if (tick && period_cnt_r != 16'hFFFF) begin
				period_cnt_r <= period_cnt_r + 16'h0001;
			end
		end
	end

	// ****************************************
	// status flags
	// ****************************************
	// sticky overflow and underflow, cleared by reading status
	always_ff @(posedge clk) begin
		if (srst) begin
			ovf_r <= 1'b0;
			unf_r <= 1'b0;
		end else begin
			ovf_r <= ovf_ev | (ovf_r & ~rd_stat);
			unf_r <= unf_ev | (unf_r & ~rd_stat);
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	wire period_ev = a_rise & seen_a_r;
	wire [3:0] ev = {period_ev, unf_ev, ovf_ev, capture};
	wire [3:0] istat_nxt = ev | (irq_stat_r & ~(wr_istat ? avm_req.writedata[3:0] : 4'h0));
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_stat_r <= 4'h0;
			irq_mask_r <= `IRQ_MASK_RST;
			irq <= 1'b0;
		end else begin
			irq_stat_r <= istat_nxt;
			if (wr_imask) begin
				irq_mask_r <= avm_req.writedata[3:0];
			end
			irq <= |(istat_nxt & (wr_imask ? avm_req.writedata[3:0] : irq_mask_r));
		end
	end

	// ****************************************
	// read mux and bus answer
	// ****************************************
	// live track levels in status byte
	wire [7:0] stat_byte = {1'b0, period_valid_r, tracks.c, tracks.b, tracks.a,
		unf_r, ovf_r, latch_valid_r};
	// control byte at offset zero, status byte at one, then words
	// count word then read-only latch word
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0000_0000;
		case (avm_req.address)
			`OFS_CTRL: rd_data = {24'h000000, ctrl_r};
			`OFS_STAT: rd_data = {24'h000000, stat_byte};
			`OFS_COUNT: rd_data = {16'h0000, count_r};
			`OFS_LATCH: rd_data = {16'h0000, latch_r};
			`OFS_PERIOD: rd_data = {16'h0000, period_r};
			`OFS_IRQ_STAT: rd_data = {28'h0000000, irq_stat_r};
			`OFS_IRQ_MASK: rd_data = {28'h0000000, irq_mask_r};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// one wait cycle: waitrequest low the cycle after the request
	always_ff @(posedge clk) begin
		if (srst) begin
			waited_r <= 1'b0;
			avm_rsp.waitrequest <= 1'b1;
			avm_rsp.readdata <= 32'h0000_0000;
		end else begin
			waited_r <= acc;
			// registered so the answer comes straight from a flop
			avm_rsp.waitrequest <= ~acc;
			if (acc) begin
				avm_rsp.readdata <= rd_data;
			end
		end
	end

	// ****************************************
	// indicators
	// ****************************************
	// indicator follows each track input
	always_ff @(posedge clk) begin
		if (srst) begin
			led <= '0;
		end else begin
			led <= tracks;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	sequence pulse_cnt_s;
		(mode == MODE_PULSE) && enabled && a_rise && !tracks.c && !wr_count;
	endsequence
	pulse_up_a: assert property (@(posedge clk) disable iff (srst)
		pulse_cnt_s ##0 !tracks.b |=> count_r == $past(count_r) + 16'h0001)
		else $error("pulse up count wrong");
	pulse_dn_a: assert property (@(posedge clk) disable iff (srst)
		pulse_cnt_s ##0 tracks.b |=> count_r == $past(count_r) - 16'h0001)
		else $error("pulse down count wrong");
	gate_hold_a: assert property (@(posedge clk) disable iff (srst)
		!srst && (mode == MODE_PULSE) && tracks.c && !wr_count |=> $stable(count_r))
		else $error("gate did not freeze");
	enc_fwd_a: assert property (@(posedge clk) disable iff (srst)
		enabled && (mode == MODE_ENCODER) && !wr_count && a_rise && !b_chg && !tracks.b
		|=> count_r == $past(count_r) + 16'h0001)
		else $error("encoder forward step wrong");
	set_load_a: assert property (@(posedge clk) disable iff (srst)
		wr_count |=> count_r == $past(avm_req.writedata[15:0]))
		else $error("set did not load");
	latch_cap_a: assert property (@(posedge clk) disable iff (srst)
		capture |=> latch_r == $past(count_r) && latch_valid_r)
		else $error("latch capture wrong");
	ovf_flag_a: assert property (@(posedge clk) disable iff (srst)
		ovf_ev |=> ovf_r && count_r == 16'h0000)
		else $error("overflow not flagged");
	led_follow_a: assert property (@(posedge clk) disable iff (srst)
		!srst |=> led == $past(tracks))
		else $error("indicator mismatch");
	bus_ans_a: assert property (@(posedge clk) disable iff (srst)
		acc |=> !avm_rsp.waitrequest ##1 avm_rsp.waitrequest)
		else $error("bus answer timing wrong");
	period_a: assert property (@(posedge clk) disable iff (srst)
		a_rise && seen_a_r |=> period_r == $past(period_cnt_r))
		else $error("period not stored");

	// ****************************************
	// counting, flag and read-back checks
	// ****************************************
	// bus reads as they are taken, shared by the read-back checks
	sequence stat_read_s;
		!srst && acc && avm_req.read && (avm_req.address == `OFS_STAT);
	endsequence
	sequence count_read_s;
		!srst && acc && avm_req.read && (avm_req.address == `OFS_COUNT);
	endsequence
	sequence ctrl_read_s;
		!srst && acc && avm_req.read && (avm_req.address == `OFS_CTRL);
	endsequence
	// a fresh arm that no index pulse meets in the same cycle
	sequence arm_only_s;
		!srst && arm_set && !capture;
	endsequence
	enc_bwd_a: assert property (@(posedge clk) disable iff (srst)
		!srst && enabled && (mode == MODE_ENCODER) && !wr_count && a_rise && !b_chg && tracks.b
		|=> count_r == $past(count_r) - 16'h0001)
		else $error("encoder backward step wrong");
	enc_bstep_a: assert property (@(posedge clk) disable iff (srst)
		!srst && enabled && (mode == MODE_ENCODER) && !wr_count && b_chg && !a_chg
		&& (tracks.a == tracks.b) |=> count_r == $past(count_r) + 16'h0001)
		else $error("encoder track b step wrong");
	enc_both_a: assert property (@(posedge clk) disable iff (srst)
		!srst && (mode == MODE_ENCODER) && a_chg && b_chg && !wr_count |=> $stable(count_r))
		else $error("double change counted");
	dis_hold_a: assert property (@(posedge clk) disable iff (srst)
		!srst && !enabled && !wr_count |=> $stable(count_r))
		else $error("disabled counter moved");
	pls_edge_a: assert property (@(posedge clk) disable iff (srst)
		!srst && (mode == MODE_PULSE) && !a_rise && !wr_count |=> $stable(count_r))
		else $error("pulse count without rising edge");
	unf_flag_a: assert property (@(posedge clk) disable iff (srst)
		!srst && unf_ev |=> unf_r && count_r == 16'hFFFF)
		else $error("underflow not flagged");
	flag_clear_a: assert property (@(posedge clk) disable iff (srst)
		!srst && rd_stat && !ovf_ev |=> !ovf_r)
		else $error("overflow flag not cleared");
	arm_clear_a: assert property (@(posedge clk) disable iff (srst)
		arm_only_s |=> arm_r && !latch_valid_r)
		else $error("arm did not take");
	arm_use_a: assert property (@(posedge clk) disable iff (srst)
		!srst && capture && !arm_set |=> !arm_r)
		else $error("arm kept after capture");
	irq_level_a: assert property (@(posedge clk) disable iff (srst)
		irq == |(irq_stat_r & irq_mask_r))
		else $error("interrupt level wrong");
	stat_keep_a: assert property (@(posedge clk) disable iff (srst)
		!srst && irq_stat_r[`EV_OVERFLOW] && !wr_istat |=> irq_stat_r[`EV_OVERFLOW])
		else $error("event bit lost");
	live_lines_a: assert property (@(posedge clk) disable iff (srst)
		stat_read_s |=> avm_rsp.readdata[5:3] ==
		{$past(tracks.c), $past(tracks.b), $past(tracks.a)})
		else $error("track levels not reported");
	count_word_a: assert property (@(posedge clk) disable iff (srst)
		count_read_s |=> avm_rsp.readdata == {16'h0000, $past(count_r)})
		else $error("count word read wrong");
	ctrl_byte_a: assert property (@(posedge clk) disable iff (srst)
		ctrl_read_s |=> avm_rsp.readdata == {24'h000000, $past(ctrl_r)})
		else $error("control byte read wrong");
	latch_ro_a: assert property (@(posedge clk) disable iff (srst)
		!srst && wr && (avm_req.address == `OFS_LATCH) && !capture |=> $stable(latch_r))
		else $error("latch word written");
	rst_mode_a: assert property (@(posedge clk) disable iff (srst)
		$past(srst) |-> ctrl_r == `CTRL_RST)
		else $error("default mode not restored");
	per_hold_a: assert property (@(posedge clk) disable iff (srst)
		!srst && !a_rise && !tick |=> $stable(period_cnt_r))
		else $error("period count off tick");
endmodule
`default_nettype wire
